/* logic/mcs_top.sv */
// Function
// - Combined mode 0: contactor and interlock follow their own settings.
// - Combined mode 1: contactor follows key switch; interlock gates drive and braking.
// - Coil starts at pull-in level, drops to holding level after one second.
// - Holding level 0..32767 means 0..100 percent average coil voltage.
// - Compensation on scales to nominal voltage, off to measured voltage.
// - Interlock source: 0 switch 3, 1 script, 2 key switch.
// - Sources 0 and 1 keep contactor closed for open delay, 4 ms steps.
// - Weld check bit: verify contactor open before closing.
// - Close-confirm bit: test contactor closed at the end of pull-in.
// - Key-to-capacitor difference above threshold at low current raises close failure.
// - Runtime threshold zero disables the ongoing close supervision.
// - Precharge bit: charge capacitor bank with limited current before closing.
// - Coil driver is always protected against short circuits.
// - Native bit set: built-in logic runs contactor; clear: script runs it.
//
// Design decision made here: the APB register port.
`include "mcs_defines.svh"
module mcs_top
  import mcs_pkg::*;
#(
  parameter int unsigned PULLIN_CYC   = `MCS_PULLIN_CYC,
  parameter int unsigned DLY_TICK_CYC = `MCS_DLY_LSB_CYC
) (
  input  wire logic        core_clk,         // 20 MHz clock
  input  wire logic        resetn,           // Sync reset, active low
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB access phase
  input  wire logic        pwrite,           // APB write
  input  wire logic [15:0] paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error, unmapped
  input  wire logic        key_switch_input, // Key switch pin
  input  wire logic        switch3_in,       // Switch 3 pin
  input  wire logic        contactor_fb,     // Contactor closed sense pin
  input  wire logic        coil_short,       // Coil driver overcurrent pin
  input  wire mcs_word_t   ksi_volt,         // Key switch voltage
  input  wire mcs_word_t   cap_volt,         // Capacitor voltage
  input  wire mcs_word_t   batt_volt,        // Measured battery voltage
  input  wire logic        batt_cur_low,     // Battery current is low
  output logic             coil_pwm,         // Contactor coil gate
  output logic             precharge_on,     // Precharge path on
  output logic             drive_enable,     // Drive allowed
  output logic             interlock_brake,  // Interlock braking
  output logic             irq               // Interrupt, active high
);
  ////////////////////////////////////////////////////////////////////
  // Registers
  mcs_word_t   ilk_src_ff, comp_ff, rt_thr_ff, pullin_ff, hold_ff;
  mcs_word_t   open_dly_ff, opt1_ff, opt2_ff, opt4_ff, combined_ff;
  mcs_word_t   mask_ff, script_ff, nominal_ff;
  logic [3:0]  sts_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff, pslverr_ff;
  mcs_state_e  state_ff, nxt_state;
  logic [31:0] pull_cnt_ff;
  logic [31:0] tick_cnt_ff;
  mcs_word_t   dly_cnt_ff;
  logic        ilk_on_ff, coil_en_ff, prech_ff, drive_ff, brake_ff, irq_ff;
  logic [3:0]  pins_s;
  logic        ksi_s, sw3_s, fb_s, short_s;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  mcs_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in ({coil_short, contactor_fb, switch3_in, key_switch_input}),
    .sync_out (pins_s)
  );
  assign ksi_s   = pins_s[0];
  assign sw3_s   = pins_s[1];
  assign fb_s    = pins_s[2];
  assign short_s = pins_s[3];

  ////////////////////////////////////////////////////////////////////
  // APB decode
  function automatic logic [15:0] byte_addr(input logic [13:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

  function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
    hit = (a == byte_addr(idx));
  endfunction

  wire acc      = psel && penable && !pready_ff;
  wire wr_done  = psel && penable && pready_ff && pwrite;
  wire h_ilk    = hit(paddr, `MCS_IDX_ILK_SRC);
  wire h_comp   = hit(paddr, `MCS_IDX_COMP);
  wire h_rt     = hit(paddr, `MCS_IDX_RT_THR);
  wire h_pull   = hit(paddr, `MCS_IDX_PULLIN);
  wire h_hold   = hit(paddr, `MCS_IDX_HOLD);
  wire h_dly    = hit(paddr, `MCS_IDX_OPEN_DLY);
  wire h_opt1   = hit(paddr, `MCS_IDX_OPT1);
  wire h_opt2   = hit(paddr, `MCS_IDX_OPT2);
  wire h_opt4   = hit(paddr, `MCS_IDX_OPT4);
  wire h_comb   = hit(paddr, `MCS_IDX_COMBINED);
  wire h_sts    = hit(paddr, `MCS_IDX_STATUS);
  wire h_mask   = hit(paddr, `MCS_IDX_MASK);
  wire h_scr    = hit(paddr, `MCS_IDX_SCRIPT);
  wire h_nom    = hit(paddr, `MCS_IDX_NOMINAL);
  wire h_state  = hit(paddr, `MCS_IDX_STATE);
  wire mapped   = h_ilk | h_comp | h_rt | h_pull | h_hold | h_dly | h_opt1
                | h_opt2 | h_opt4 | h_comb | h_sts | h_mask | h_scr | h_nom
                | h_state;
  wire [15:0] rd_word =
      h_ilk   ? ilk_src_ff  : h_comp ? comp_ff     : h_rt   ? rt_thr_ff  :
      h_pull  ? pullin_ff   : h_hold ? hold_ff     : h_dly  ? open_dly_ff :
      h_opt1  ? opt1_ff     : h_opt2 ? opt2_ff     : h_opt4 ? opt4_ff    :
      h_comb  ? combined_ff : h_sts  ? {12'h000, sts_ff} :
      h_mask  ? mask_ff     : h_scr  ? script_ff   : h_nom  ? nominal_ff :
      h_state ? {10'h000, state_ff} : 16'h0000;
  wire [15:0] wd = pwdata[15:0];

  ////////////////////////////////////////////////////////////////////
  // Interlock and contactor request
  wire native   = opt1_ff[`MCS_OPT1_NATIVE];
  wire weld_on  = opt1_ff[`MCS_OPT1_WELD];
  wire prech_en = opt2_ff[`MCS_OPT2_PRECH];
  wire conf_on  = opt4_ff[`MCS_OPT4_CONFIRM];
  wire comp_on  = comp_ff[`MCS_COMP_ON];
  wire src_sw3  = (ilk_src_ff == 16'h0000);
  wire src_scr  = (ilk_src_ff == 16'h0001);
  wire src_ksi  = (ilk_src_ff == 16'h0002);
  wire ilk_on   = src_sw3 ? sw3_s
                : src_scr ? script_ff[`MCS_SCR_ILK]
                : src_ksi ? ksi_s : 1'b0;
  wire dly_src  = src_sw3 | src_scr;
  wire ilk_fall = ilk_on_ff && !ilk_on;
  wire tick     = (tick_cnt_ff == DLY_TICK_CYC - 1);
  // The counter loads one cycle after the fall, so the fall cycle itself must hold too
  wire dly_hold = dly_src && ((dly_cnt_ff != 16'h0000)
                              || (ilk_fall && (open_dly_ff != 16'h0000)));
  wire own_req  = native ? (ilk_on | dly_hold)
                         : script_ff[`MCS_SCR_MAIN];
  wire main_req = (combined_ff == 16'h0001) ? ksi_s
                                            : own_req;

  ////////////////////////////////////////////////////////////////////
  // Supervision
  wire [15:0] v_diff  = (ksi_volt > cap_volt) ? (ksi_volt - cap_volt) : 16'h0000;
  wire rt_fail  = (rt_thr_ff != 16'h0000)
                && (v_diff > rt_thr_ff) && batt_cur_low;
  wire prech_ok = (v_diff <= `MCS_PRECH_MARGIN);
  wire weld_bad = (state_ff == ST_WELD) && weld_on && fb_s;
  wire pull_end = (state_ff == ST_PULLIN) && (pull_cnt_ff == PULLIN_CYC - 1);
  wire conf_bad = pull_end && conf_on && !fb_s;
  wire rt_bad   = (state_ff == ST_HOLD) && rt_fail;
  wire closed_ev = pull_end && !conf_bad;
  wire [3:0] ev = {closed_ev, short_s && coil_en_ff,
                   conf_bad | rt_bad, weld_bad};
  wire [3:0] w1c = (wr_done && h_sts) ? wd[3:0] : 4'h0;
  wire faults   = |sts_ff[2:0];

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:   if (main_req && !faults) begin
                   nxt_state = ST_WELD;
                 end
      ST_WELD:   if (!main_req) begin
                   nxt_state = ST_IDLE;
                 end else if (weld_bad) begin
                   nxt_state = ST_FAULT;
                 end else begin
                   nxt_state = prech_en ? ST_PRECH : ST_PULLIN;
                 end
      ST_PRECH:  if (!main_req) begin
                   nxt_state = ST_IDLE;
                 end else if (prech_ok) begin
                   nxt_state = ST_PULLIN;
                 end
      ST_PULLIN: if (!main_req) begin
                   nxt_state = ST_IDLE;
                 end else if (conf_bad) begin
                   nxt_state = ST_FAULT;
                 end else if (pull_end) begin
                   nxt_state = ST_HOLD;
                 end
      ST_HOLD:   if (!main_req) begin
                   nxt_state = ST_IDLE;
                 end else if (rt_bad) begin
                   nxt_state = ST_FAULT;
                 end
      ST_FAULT:  if (!faults && !main_req) begin
                   nxt_state = ST_IDLE;
                 end
      default:   nxt_state = ST_FAULT;
    endcase
    if (short_s) begin
      nxt_state = ST_FAULT;
    end
  end

  wire coil_next = ((nxt_state == ST_PULLIN) || (nxt_state == ST_HOLD)) && !short_s;
  wire [15:0] level = (state_ff == ST_PULLIN) ? pullin_ff : hold_ff;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_ff    <= ST_IDLE;
      pull_cnt_ff <= 32'h0000_0000;
      coil_en_ff  <= 1'b0;
      prech_ff    <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      pull_cnt_ff <= (state_ff == ST_PULLIN) ? pull_cnt_ff + 32'h0000_0001
                                             : 32'h0000_0000;
      coil_en_ff  <= coil_next;
      prech_ff    <= (nxt_state == ST_PRECH);
    end
  end

  // Open delay countdown, one step per tick
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ilk_on_ff   <= 1'b0;
      tick_cnt_ff <= 32'h0000_0000;
      dly_cnt_ff  <= 16'h0000;
    end else begin
      ilk_on_ff   <= ilk_on;
      tick_cnt_ff <= (tick || ilk_fall) ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
      if (ilk_on) begin
        dly_cnt_ff <= 16'h0000;
      end else if (ilk_fall) begin
        dly_cnt_ff <= open_dly_ff;
      end else if (tick && dly_cnt_ff != 16'h0000) begin
        dly_cnt_ff <= dly_cnt_ff - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs and status
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      sts_ff   <= 4'h0;
      drive_ff <= 1'b0;
      brake_ff <= 1'b0;
      irq_ff   <= 1'b0;
    end else begin
      sts_ff   <= (sts_ff & ~w1c) | ev;
      drive_ff <= ilk_on && (state_ff == ST_HOLD);
      brake_ff <= !ilk_on;
      irq_ff   <= |(sts_ff & mask_ff[3:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave, one wait state
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= acc && !mapped;
      prdata_ff  <= (acc && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ilk_src_ff  <= `MCS_RST_ZERO;
      comp_ff     <= `MCS_RST_ZERO;
      rt_thr_ff   <= `MCS_RST_ZERO;
      pullin_ff   <= `MCS_RST_PULLIN;
      hold_ff     <= `MCS_RST_HOLD;
      open_dly_ff <= `MCS_RST_ZERO;
      opt1_ff     <= `MCS_RST_ZERO;
      opt2_ff     <= `MCS_RST_ZERO;
      opt4_ff     <= `MCS_RST_ZERO;
      combined_ff <= `MCS_RST_ZERO;
      mask_ff     <= `MCS_RST_ZERO;
      script_ff   <= `MCS_RST_ZERO;
      nominal_ff  <= `MCS_RST_NOMINAL;
    end else if (wr_done) begin
      if (h_ilk)  ilk_src_ff  <= wd;
      if (h_comp) comp_ff     <= wd;
      if (h_rt)   rt_thr_ff   <= wd;
      if (h_pull) pullin_ff   <= wd;
      if (h_hold) hold_ff     <= wd;
      if (h_dly)  open_dly_ff <= wd;
      if (h_opt1) opt1_ff     <= wd;
      if (h_opt2) opt2_ff     <= wd;
      if (h_opt4) opt4_ff     <= wd;
      if (h_comb) combined_ff <= wd;
      if (h_mask) mask_ff     <= wd;
      if (h_scr)  script_ff   <= wd;
      if (h_nom)  nominal_ff  <= wd;
    end
  end

  mcs_coil_pwm u_pwm (
    .core_clk (core_clk),
    .resetn   (resetn),
    .enable   (coil_en_ff),
    .level    (level),
    .comp_on  (comp_on),
    .nom_v    (nominal_ff),
    .act_v    (batt_volt),
    .pwm_out  (coil_pwm)
  );

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign precharge_on    = prech_ff;
  assign drive_enable    = drive_ff;
  assign interlock_brake = brake_ff;
  assign irq             = irq_ff;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_combined_mode_ksi: assert property (
    (combined_ff == 16'h0001) |-> (main_req == ksi_s)) else $error("mode 1 ignores key");
  a_indep_native: assert property (
    (combined_ff == 16'h0000) && native |-> (main_req == (ilk_on | dly_hold)))
    else $error("mode 0 request wrong");
  a_ilk_source: assert property (
    src_ksi |-> (ilk_on == ksi_s)) else $error("source 2 not key");
  a_pullin_drop: assert property (
    pull_end && main_req && !conf_bad && !short_s |=> (state_ff == ST_HOLD))
    else $error("no hold after pull-in");
  a_hold_level: assert property (
    (state_ff == ST_HOLD) |-> (level == hold_ff)) else $error("hold level wrong");
  a_open_delay: assert property (
    ilk_fall && !ilk_on && (open_dly_ff != 16'h0000) |=> (dly_cnt_ff == $past(open_dly_ff)))
    else $error("open delay not loaded");
  a_weld_fault: assert property (
    weld_bad |=> sts_ff[`MCS_ST_WELD] && (state_ff == ST_FAULT)) else $error("weld missed");
  a_weld_blocks: assert property (
    sts_ff[`MCS_ST_WELD] |-> !coil_next) else $error("close despite weld");
  a_confirm: assert property (
    conf_bad |=> sts_ff[`MCS_ST_CLOSE_FAIL]) else $error("close confirm missed");
  a_rt_zero_off: assert property (
    (rt_thr_ff == 16'h0000) |-> !rt_bad) else $error("zero threshold trips");
  a_rt_fault: assert property (
    rt_bad |=> sts_ff[`MCS_ST_CLOSE_FAIL] ##1 !coil_en_ff) else $error("runtime fault missed");
  a_prech_first: assert property (
    (state_ff == ST_WELD) && main_req && !weld_bad && prech_en && !short_s
    |=> precharge_on ##0 !coil_en_ff) else $error("precharge skipped");
  a_short_off: assert property (
    short_s |=> !coil_en_ff ##2 !coil_pwm) else $error("coil on in short");
  a_script_main: assert property (
    (combined_ff == 16'h0000) && !native |-> (main_req == script_ff[`MCS_SCR_MAIN]))
    else $error("script request wrong");

  c_reach_hold:  cover property ((state_ff == ST_PULLIN) ##1 (state_ff == ST_HOLD));
  c_weld_fault:  cover property (weld_bad);
  c_rt_fault:    cover property (rt_bad);
  c_delay_hold:  cover property (dly_hold && !ilk_on && (state_ff == ST_HOLD));
endmodule

/* logic/mcs_defines.svh */
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH
// Register indices; byte address is index times four
`define MCS_IDX_ILK_SRC   14'h300e
`define MCS_IDX_COMP      14'h302c
`define MCS_IDX_RT_THR    14'h3032
`define MCS_IDX_PULLIN    14'h303c
`define MCS_IDX_HOLD      14'h303d
`define MCS_IDX_OPEN_DLY  14'h303f
`define MCS_IDX_OPT1      14'h306a
`define MCS_IDX_OPT2      14'h306b
`define MCS_IDX_OPT4      14'h306d
`define MCS_IDX_COMBINED  14'h386f
`define MCS_IDX_STATUS    14'h3100
`define MCS_IDX_MASK      14'h3101
`define MCS_IDX_SCRIPT    14'h3102
`define MCS_IDX_NOMINAL   14'h3103
`define MCS_IDX_STATE     14'h3104
// Field positions
`define MCS_OPT1_NATIVE   0
`define MCS_OPT1_WELD     2
`define MCS_OPT2_PRECH    6
`define MCS_OPT4_CONFIRM  7
`define MCS_COMP_ON       0
`define MCS_SCR_MAIN      0
`define MCS_SCR_ILK       1
`define MCS_ST_WELD       0
`define MCS_ST_CLOSE_FAIL 1
`define MCS_ST_SHORT      2
`define MCS_ST_CLOSED     3
// Reset values
`define MCS_RST_ZERO      16'h0000
`define MCS_RST_PULLIN    16'h7fff
`define MCS_RST_HOLD      16'h4000
`define MCS_RST_NOMINAL   16'h0c00
`define MCS_LEVEL_MAX     16'h7fff
// Timing: clock in kHz, pull-in in ms, open delay step in us
`define MCS_CLK_KHZ       20000
`define MCS_PULLIN_MS     1000
`define MCS_PULLIN_CYC    (`MCS_PULLIN_MS * `MCS_CLK_KHZ)
`define MCS_DLY_LSB_US    4000
`define MCS_DLY_LSB_CYC   (`MCS_DLY_LSB_US * `MCS_CLK_KHZ / 1000)
`define MCS_PRECH_MARGIN  16'h0100
`endif

/* logic/mcs_pkg.sv */
package mcs_pkg;
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_WELD   = 6'b000010,
    ST_PRECH  = 6'b000100,
    ST_PULLIN = 6'b001000,
    ST_HOLD   = 6'b010000,
    ST_FAULT  = 6'b100000
  } mcs_state_e;
  typedef logic [15:0] mcs_word_t;
endpackage

/* logic/mcs_sync.sv */
module mcs_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk, // Clock
  input  wire logic         resetn,   // Sync reset, active low
  input  wire logic [W-1:0] async_in, // Pin levels
  output logic      [W-1:0] sync_out  // Filtered levels
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] nxt_out;

  // A change counts once stages two and three agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    assign nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : sync_out[i];
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      sync_out <= '0;
    end else begin
      s1_ff    <= async_in;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      sync_out <= nxt_out;
    end
  end
endmodule

/* logic/mcs_coil_pwm.sv */
`include "mcs_defines.svh"
module mcs_coil_pwm
  import mcs_pkg::*;
(
  input  wire logic      core_clk, // Clock
  input  wire logic      resetn,   // Sync reset, active low
  input  wire logic      enable,   // Coil drive on
  input  wire mcs_word_t level,    // 0..32767 = 0..100 %
  input  wire logic      comp_on,  // Scale to nominal voltage
  input  wire mcs_word_t nom_v,    // Nominal battery voltage
  input  wire mcs_word_t act_v,    // Measured battery voltage
  output logic           pwm_out   // Coil gate
);
  logic [31:0] prod;
  logic [31:0] quot;
  mcs_word_t   scaled;
  mcs_word_t   duty_ff;
  logic [14:0] cnt_ff;

  // Compensation keeps coil volts = nominal x level despite bus swings
  assign prod   = 32'(level) * 32'(nom_v);
  assign quot   = (act_v == 16'h0000) ? 32'(`MCS_LEVEL_MAX) : prod / 32'(act_v);
  assign scaled = comp_on ? ((quot > 32'(`MCS_LEVEL_MAX)) ? `MCS_LEVEL_MAX : quot[15:0])
                          : level;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      duty_ff <= 16'h0000;
      cnt_ff  <= 15'h0000;
      pwm_out <= 1'b0;
    end else begin
      duty_ff <= scaled;
      cnt_ff  <= cnt_ff + 15'h0001;
      pwm_out <= enable && ({1'b0, cnt_ff} < duty_ff);
    end
  end
endmodule

/* test/mcs_coil_model.sv */
module mcs_coil_model
  import mcs_pkg::*;
(
  input  wire logic      core_clk,     // Clock
  input  wire logic      coil_pwm,     // Coil gate
  input  wire logic      precharge_on, // Precharge path on
  input  wire logic      welded,       // Tips stuck shut
  input  wire logic      stuck,        // Tips never close
  input  wire logic      slow,         // Slow armature
  input  wire mcs_word_t sag,          // Drop across closed tips
  output logic           contactor_fb, // Tips closed
  output mcs_word_t      ksi_volt,     // Key switch voltage
  output mcs_word_t      cap_volt,     // Capacitor voltage
  output mcs_word_t      batt_volt     // Battery voltage
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] on_cnt = 8'h00;
  logic [3:0] off_cnt = 4'h0;
  assign ksi_volt = 16'h0c00;
  assign batt_volt = 16'h0c00;
  // Armature falls out only after eight cycles without coil current
  assign contactor_fb = welded | (!stuck && on_cnt >= (slow ? 8'h28 : 8'h03));
  always @(posedge core_clk) begin
    off_cnt <= coil_pwm ? 4'h0 : off_cnt + {3'h0, off_cnt != 4'hf};
    if (coil_pwm) begin
      on_cnt <= on_cnt + {7'h0, on_cnt != 8'hff};
    end else if (off_cnt >= 4'h8) begin
      on_cnt <= 8'h00;
    end
    cap_volt <= contactor_fb ? ksi_volt - sag : precharge_on ? cap_volt + 16'h0010 : cap_volt >> 1;
  end
endmodule

/* test/testbench.sv */
`include "mcs_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mcs_pkg::*;
  localparam logic [13:0] SCR = `MCS_IDX_SCRIPT, ST = `MCS_IDX_STATE, SS = `MCS_IDX_STATUS;
  logic        core_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic        key_switch_input, switch3_in, contactor_fb, coil_short, batt_cur_low;
  logic        coil_pwm, precharge_on, drive_enable, interlock_brake, irq, welded, stuck, slow;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  mcs_word_t   ksi_volt, cap_volt, batt_volt, sag;
  int          errors, checks_done, n;
  wire  [31:0] ilk = {30'h0, drive_enable, interlock_brake};
  mcs_top #(.PULLIN_CYC(200), .DLY_TICK_CYC(10)) u_mcs_top (.core_clk(core_clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .key_switch_input(key_switch_input), .switch3_in(switch3_in), .coil_short(coil_short),
    .contactor_fb(contactor_fb), .ksi_volt(ksi_volt), .cap_volt(cap_volt),
    .batt_volt(batt_volt), .batt_cur_low(batt_cur_low), .coil_pwm(coil_pwm),
    .precharge_on(precharge_on), .drive_enable(drive_enable),
    .interlock_brake(interlock_brake));
  mcs_coil_model u_mcs_coil_model (.core_clk(core_clk), .coil_pwm(coil_pwm),
    .precharge_on(precharge_on), .welded(welded), .stuck(stuck), .slow(slow), .sag(sag),
    .contactor_fb(contactor_fb), .ksi_volt(ksi_volt), .cap_volt(cap_volt),
    .batt_volt(batt_volt));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input int unsigned exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic bail;
    errors++;
    $display("[FAIL] %0t ns: wait ran out", $time);
    tally_and_finish();
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [13:0] idx, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, idx, 2'b00, 16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) bail();
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [13:0] idx, input int unsigned exp);
    apb(1'b0, idx, 16'h0000);
    chk(rd, exp);
  endtask
  task automatic wst(input logic [5:0] s, input int lim);
    n = 0;
    do begin
      apb(1'b0, ST, 16'h0000);
      n++;
    end while (rd[5:0] !== s && n < lim);
    if (rd[5:0] !== s) bail();
  endtask
  task automatic rst(input logic hold);
    resetn <= 1'b0;
    {welded, stuck, slow, coil_short, batt_cur_low, key_switch_input, switch3_in} <= 7'h00;
    sag <= 16'h0000;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    if (hold) wr(`MCS_IDX_HOLD, 16'h7ffc);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_regs;
    rdc(`MCS_IDX_PULLIN, 32'h7fff);
    rdc(`MCS_IDX_HOLD, 32'h4000);
    rdc(`MCS_IDX_NOMINAL, 32'h0c00);
    rdc(`MCS_IDX_RT_THR, 0);
    wr(`MCS_IDX_HOLD, 16'h7ffc);
    rdc(`MCS_IDX_HOLD, 32'h7ffc);
    wr(14'h0001, 16'hffff);
    chk(32'(err), 1);
    rdc(14'h0001, 0);
    chk(32'(err), 1);
  endtask
  task automatic s_script;
    rst(1'b1);
    slow <= 1'b1;
    wr(`MCS_IDX_MASK, 16'h0008);
    wr(SCR, 16'h0001);
    wst(6'h08, 20);
    wst(6'h10, 80);
    chk(32'(n >= 48 && n <= 52), 1);
    repeat (100) @(posedge core_clk);
    chk(32'(contactor_fb), 1);
    chk(ilk, 1);
    rdc(SS, 32'h0008);
    chk(32'(irq), 1);
    wr(`MCS_IDX_MASK, 16'h0000);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 0);
    wr(`MCS_IDX_MASK, 16'h0008);
    wr(SS, 16'h0008);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 0);
    rdc(SS, 0);
    wr(SCR, 16'h0000);
    wst(6'h01, 20);
  endtask
  task automatic s_weld;
    rst(1'b1);
    welded <= 1'b1;
    wr(`MCS_IDX_OPT1, 16'h0004);
    wr(`MCS_IDX_MASK, 16'h0001);
    wr(SCR, 16'h0001);
    wst(6'h20, 20);
    rdc(SS, 32'h0001);
    chk({30'h0, coil_pwm, irq}, 1);
    welded <= 1'b0;
    repeat (10) @(posedge core_clk);
    rdc(ST, 32'h0020);
    wr(SCR, 16'h0000);
    wr(SS, 16'h0001);
    wst(6'h01, 20);
    chk(32'(irq), 0);
    welded <= 1'b1;
    wr(`MCS_IDX_OPT1, 16'h0000);
    wr(SCR, 16'h0001);
    wst(6'h10, 120);
  endtask
  task automatic s_short;
    rst(1'b1);
    wr(SCR, 16'h0001);
    wst(6'h10, 120);
    coil_short <= 1'b1;
    wst(6'h20, 10);
    rdc(SS, 32'h000c);
    repeat (20) @(posedge core_clk);
    chk(32'(contactor_fb), 0);
  endtask
  task automatic s_confirm;
    rst(1'b1);
    stuck <= 1'b1;
    wr(`MCS_IDX_OPT4, 16'h0080);
    wr(SCR, 16'h0001);
    wst(6'h20, 80);
    rdc(SS, 32'h0002);
    rst(1'b1);
    {stuck, batt_cur_low} <= 2'b11;
    wr(SCR, 16'h0001);
    wst(6'h10, 80);
    repeat (60) @(posedge core_clk);
    rdc(ST, 32'h0010);
  endtask
  task automatic s_runtime;
    rst(1'b1);
    wr(`MCS_IDX_RT_THR, 16'h0200);
    {sag, batt_cur_low} <= {16'h0200, 1'b1};
    wr(SCR, 16'h0001);
    wst(6'h10, 80);
    repeat (20) @(posedge core_clk);
    rdc(ST, 32'h0010);
    {sag, batt_cur_low} <= {16'h0201, 1'b0};
    repeat (20) @(posedge core_clk);
    rdc(ST, 32'h0010);
    batt_cur_low <= 1'b1;
    wst(6'h20, 10);
    rdc(SS, 32'h000a);
  endtask
  task automatic s_prech;
    rst(1'b1);
    wr(`MCS_IDX_OPT2, 16'h0040);
    wr(SCR, 16'h0001);
    wst(6'h04, 20);
    chk({30'h0, precharge_on, contactor_fb}, 2);
    wst(6'h08, 80);
    chk(32'(precharge_on), 0);
  endtask
  task automatic s_src;
    for (int s = 0; s < 3; s++) begin
      rst(1'b1);
      wr(`MCS_IDX_OPT1, 16'h0001);
      wr(`MCS_IDX_ILK_SRC, 16'(s));
      wr(`MCS_IDX_OPEN_DLY, 16'h0014);
      {switch3_in, key_switch_input} <= {s == 0, s == 2};
      wr(SCR, {14'h0, s == 1, 1'b0});
      wst(6'h10, 120);
      chk(ilk, 2);
      {switch3_in, key_switch_input} <= 2'b00;
      wr(SCR, 16'h0000);
      wst(6'h01, 80);
      chk(32'(s < 2 ? n >= 44 && n <= 54 : n <= 5), 1);
    end
  endtask
  task automatic s_comb;
    rst(1'b1);
    wr(`MCS_IDX_OPT1, 16'h0001);
    key_switch_input <= 1'b1;
    repeat (40) @(posedge core_clk);
    rdc(ST, 32'h0001);
    wr(`MCS_IDX_COMBINED, 16'h0001);
    wst(6'h10, 120);
    chk(ilk, 1);
    switch3_in <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(ilk, 2);
  endtask
  task automatic s_comp;
    rst(1'b1);
    wr(`MCS_IDX_COMP, 16'h0001);
    wr(`MCS_IDX_NOMINAL, 16'h0600);
    wr(SCR, 16'h0001);
    wst(6'h10, 80);
    n = 0;
    repeat (32768) begin
      @(posedge core_clk);
      n += int'(coil_pwm === 1'b1);
    end
    chk(32'(n), 32'h3ffe);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    errors = 0;
    checks_done = 0;
    rst(1'b0);
    s_regs();
    s_script();
    s_weld();
    s_short();
    s_confirm();
    s_runtime();
    s_prech();
    s_src();
    s_comb();
    s_comp();
    tally_and_finish();
  end
endmodule
